// File: gpp_pin_model.sv
// External devices on the port pins: resolves each wire for the port input
`timescale 1ns/1ps
`default_nettype none

module gpp_pin_model (
    // Clock
    input  wire logic        mclk_i,
    // Port side
    input  wire logic [31:0] pin_o_i,
    input  wire logic [31:0] pin_oe_n_i,
    input  wire logic [31:0] pulldown_en_i,
    // External devices
    input  wire logic [31:0] ext_val_i,
    input  wire logic [31:0] ext_en_i,
    output logic      [31:0] level_o
);
    logic [31:0] float_reg = 32'h5555_5555;

    // A floating, unpulled pin wanders so a stale level can never pass
    always_ff @(posedge mclk_i) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pin_oe_n_i[i] == 1'b0) begin
                level_o[i] = pin_o_i[i];
            end else if (ext_en_i[i] == 1'b1) begin
                level_o[i] = ext_val_i[i];
            end else if (pulldown_en_i[i] == 1'b1) begin
                level_o[i] = 1'b0;
            end else begin
                level_o[i] = float_reg[i];
            end
        end
    end
endmodule : gpp_pin_model

`default_nettype wire

// File: gpp_pkg.sv
// Register map, field layout and reset values for the general-purpose I/O port
package gpp_pkg;

    localparam int unsigned ADDR_W    = 16;
    localparam int unsigned DATA_W    = 16;
    localparam int unsigned PIN_COUNT = 32;

    // Word offsets of the port's registers
    localparam logic [15:0] PIN_DIRECTION_LO_OFS   = 16'h1C06;
    localparam logic [15:0] PIN_DIRECTION_HI_OFS   = 16'h1C07;
    localparam logic [15:0] PIN_LEVEL_READ_LO_OFS  = 16'h1C08;
    localparam logic [15:0] PIN_LEVEL_READ_HI_OFS  = 16'h1C09;
    localparam logic [15:0] PIN_DRIVE_VALUE_LO_OFS = 16'h1C0A;
    localparam logic [15:0] PIN_DRIVE_VALUE_HI_OFS = 16'h1C0B;
    localparam logic [15:0] IRQ_EDGE_SELECT_LO_OFS = 16'h1C0C;
    localparam logic [15:0] IRQ_EDGE_SELECT_HI_OFS = 16'h1C0D;
    localparam logic [15:0] IRQ_ENABLE_LO_OFS      = 16'h1C0E;
    localparam logic [15:0] IRQ_ENABLE_HI_OFS      = 16'h1C0F;
    localparam logic [15:0] IRQ_PENDING_LO_OFS     = 16'h1C10;
    localparam logic [15:0] IRQ_PENDING_HI_OFS     = 16'h1C11;
    localparam logic [15:0] PIN_ROUTING_SELECT_OFS = 16'h1C00;
    localparam logic [15:0] PULLDOWN_INHIBIT_LO_OFS = 16'h1C17;
    localparam logic [15:0] PULLDOWN_INHIBIT_HI_OFS = 16'h1C18;

    // Pins that may be in use at once: 31..27 and 20..0
    localparam logic [31:0] USABLE_PINS = 32'hF81F_FFFF;

    // Reset values
    localparam logic [31:0] PORT_RST      = 32'h0000_0000;
    localparam logic [15:0] ROUTING_RST   = 16'h0000;
    localparam logic [15:0] READ_ZERO     = 16'h0000;

    // Edge select encoding per pin
    localparam logic EDGE_RISING  = 1'b0;
    localparam logic EDGE_FALLING = 1'b1;

    typedef struct packed {
        logic [31:0] dir;
        logic [31:0] drive;
        logic [31:0] edge_sel;
        logic [31:0] irq_en;
        logic [31:0] pending;
        logic [31:0] pd_inhibit;
        logic [15:0] routing;
        logic [31:0] sync1;
        logic [31:0] sync2;
        logic [31:0] sync_prev;
        logic [15:0] rdata;
        logic        irq_n;
        logic [31:0] pin_o;
        logic [31:0] pin_oe_n;
        logic [31:0] pd_en;
        logic [15:0] routing_o;
    } gpp_state_t;

endpackage : gpp_pkg

// File: gpp_port.sv
// General-purpose I/O port: registers, pin drive, input sync and edge interrupts
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module gpp_port #(
    parameter int unsigned PINS = 32
) (
    // Clock and hardware reset
    input  wire logic                         mclk_i,
    input  wire logic                         rst_n_i,
    // Register port
    input  wire logic [gpp_pkg::ADDR_W-1:0]   addr_i,
    input  wire logic [gpp_pkg::DATA_W-1:0]   wdata_i,
    input  wire logic                         wr_i,
    input  wire logic                         rd_i,
    output logic      [gpp_pkg::DATA_W-1:0]   rdata_o,
    // Pins
    input  wire logic [31:0]                  pin_i,
    output logic      [31:0]                  pin_o,
    output logic      [31:0]                  pin_oe_n_o,
    output logic      [31:0]                  pulldown_en_o,
    // System side
    output logic      [15:0]                  pin_routing_o,
    output logic                              irq_n_o
);
    import gpp_pkg::*;

    if (PINS != 32) begin : g_chk
        $error("gpp_port supports exactly 32 pin positions");
    end

    gpp_state_t s_reg;
    gpp_state_t s_next;

    // Picks the high half for odd pair offsets
    function automatic logic [31:0] merge_half(input logic [31:0] cur,
                                               input logic        hi,
                                               input logic [15:0] d);
        merge_half = hi ? {d, cur[15:0]} : {cur[31:16], d};
    endfunction : merge_half

    function automatic logic [15:0] pick_half(input logic [31:0] v,
                                              input logic        hi);
        pick_half = hi ? v[31:16] : v[15:0];
    endfunction : pick_half

    logic [31:0] level_view;
    logic [31:0] rise;
    logic [31:0] fall;
    logic [31:0] events;
    logic [31:0] clr_mask;

    always_comb begin
        s_next = s_reg;
        // Only the second stage and its delayed copy sync_prev are read beyond the synchroniser
        s_next.sync1     = pin_i;
        s_next.sync2     = s_reg.sync1;
        s_next.sync_prev = s_reg.sync2;

        rise   = s_reg.sync2 & ~s_reg.sync_prev;
        fall   = ~s_reg.sync2 & s_reg.sync_prev;
        events = s_reg.irq_en & USABLE_PINS
               & ((~s_reg.edge_sel & rise)
               | (s_reg.edge_sel & fall));

        level_view = (s_reg.dir & s_reg.drive)
                   | (~s_reg.dir & s_reg.sync2);

        clr_mask = 32'h0000_0000;
        if (wr_i) begin
            unique case (addr_i)
                PIN_DIRECTION_LO_OFS, PIN_DIRECTION_HI_OFS:
                    s_next.dir = merge_half(s_reg.dir, addr_i[0], wdata_i)
                               & USABLE_PINS;
                PIN_DRIVE_VALUE_LO_OFS, PIN_DRIVE_VALUE_HI_OFS:
                    s_next.drive = merge_half(s_reg.drive, addr_i[0],
                                              wdata_i);
                IRQ_EDGE_SELECT_LO_OFS, IRQ_EDGE_SELECT_HI_OFS:
                    s_next.edge_sel = merge_half(s_reg.edge_sel, addr_i[0],
                                                 wdata_i);
                IRQ_ENABLE_LO_OFS, IRQ_ENABLE_HI_OFS:
                    s_next.irq_en = merge_half(s_reg.irq_en, addr_i[0],
                                               wdata_i);
                IRQ_PENDING_LO_OFS, IRQ_PENDING_HI_OFS:
                    clr_mask = merge_half(32'h0000_0000, addr_i[0],
                                          wdata_i);
                PIN_ROUTING_SELECT_OFS:
                    s_next.routing = wdata_i;
                PULLDOWN_INHIBIT_LO_OFS:
                    s_next.pd_inhibit[15:0] = wdata_i;
                PULLDOWN_INHIBIT_HI_OFS:
                    s_next.pd_inhibit[31:16] = wdata_i;
                default: ;
            endcase
        end

        // Event wins over a clear in the same cycle
        s_next.pending = (s_reg.pending & ~clr_mask) | events;

        s_next.rdata = READ_ZERO;
        if (rd_i) begin
            unique case (addr_i)
                PIN_DIRECTION_LO_OFS, PIN_DIRECTION_HI_OFS:
                    s_next.rdata = pick_half(s_reg.dir, addr_i[0]);
                PIN_LEVEL_READ_LO_OFS, PIN_LEVEL_READ_HI_OFS:
                    s_next.rdata = pick_half(level_view, addr_i[0]);
                PIN_DRIVE_VALUE_LO_OFS, PIN_DRIVE_VALUE_HI_OFS:
                    s_next.rdata = pick_half(s_reg.drive, addr_i[0]);
                IRQ_EDGE_SELECT_LO_OFS, IRQ_EDGE_SELECT_HI_OFS:
                    s_next.rdata = pick_half(s_reg.edge_sel, addr_i[0]);
                IRQ_ENABLE_LO_OFS, IRQ_ENABLE_HI_OFS:
                    s_next.rdata = pick_half(s_reg.irq_en, addr_i[0]);
                IRQ_PENDING_LO_OFS, IRQ_PENDING_HI_OFS:
                    s_next.rdata = pick_half(s_reg.pending, addr_i[0]);
                PIN_ROUTING_SELECT_OFS:
                    s_next.rdata = s_reg.routing;
                PULLDOWN_INHIBIT_LO_OFS:
                    s_next.rdata = s_reg.pd_inhibit[15:0];
                PULLDOWN_INHIBIT_HI_OFS:
                    s_next.rdata = s_reg.pd_inhibit[31:16];
                default: s_next.rdata = READ_ZERO;
            endcase
        end

        // Outputs are registered copies, updated on the same edge as config
        s_next.irq_n     = ~(|s_next.pending);
        s_next.pin_o     = s_next.drive;
        s_next.pin_oe_n  = ~s_next.dir;
        s_next.pd_en     = ~s_next.pd_inhibit & USABLE_PINS;
        s_next.routing_o = s_next.routing;
    end

    // Only the hardware reset pin reaches this flop bank
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg            <= '0;
            s_reg.irq_n      <= 1'b1;
            s_reg.pin_oe_n   <= ~PORT_RST;
            s_reg.pd_en      <= USABLE_PINS;
            s_reg.routing    <= ROUTING_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_o       = s_reg.rdata;
    assign pin_o         = s_reg.pin_o;
    assign pin_oe_n_o    = s_reg.pin_oe_n;
    assign pulldown_en_o = s_reg.pd_en;
    assign pin_routing_o = s_reg.routing_o;
    assign irq_n_o       = s_reg.irq_n;

    // Assertions
    irq_level_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        irq_n_o == ~(|s_reg.pending))
        else $error("interrupt line disagrees with flags");

    flag_rise_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (s_reg.irq_en[0] && !s_reg.edge_sel[0] && s_reg.sync2[0]
         && !s_reg.sync_prev[0]) |=> s_reg.pending[0])
        else $error("rising edge did not set flag 0");

    flag_fall_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (s_reg.irq_en[1] && s_reg.edge_sel[1] && !s_reg.sync2[1]
         && s_reg.sync_prev[1]) |=> s_reg.pending[1])
        else $error("falling edge did not set flag 1");

    no_enable_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (!s_reg.pending[2] && !s_reg.irq_en[2]) |=> !s_reg.pending[2])
        else $error("disabled pin raised a flag");

    flag_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wr_i && addr_i == IRQ_PENDING_LO_OFS && wdata_i[3] && !events[3])
        |=> !s_reg.pending[3])
        else $error("write one did not clear flag 3");

    set_wins_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        events[4] |=> s_reg.pending[4])
        else $error("event lost against clear");

    out_drive_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wr_i && addr_i == PIN_DRIVE_VALUE_LO_OFS) |=> ##1
        (pin_o[15:0] == $past(wdata_i, 2)))
        else $error("pin drive does not follow written value");

    read_level_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (rd_i && addr_i == PIN_LEVEL_READ_LO_OFS && !s_reg.dir[5])
        |=> rdata_o[5] == $past(s_reg.sync2[5]))
        else $error("input readback wrong");

    read_out_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (rd_i && addr_i == PIN_LEVEL_READ_LO_OFS && s_reg.dir[6])
        |=> rdata_o[6] == $past(s_reg.drive[6]))
        else $error("output readback wrong");

    routing_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (wr_i && addr_i == PIN_ROUTING_SELECT_OFS) |=> ##1
        pin_routing_o == $past(wdata_i, 2))
        else $error("routing not applied");

    dead_pin_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        pin_oe_n_o[24:21] == 4'hF && !s_reg.pending[22])
        else $error("unusable pin became active");

endmodule : gpp_port

`default_nettype wire

// File: gpp_tb.sv
// Self-checking testbench for the general-purpose I/O port
`timescale 1ns/1ps
`default_nettype none

module tb;
    import gpp_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic [31:0] pin_i, pin_o, pin_oe_n_o, pulldown_en_o;
    logic [15:0] pin_routing_o;
    logic        irq_n_o;
    // Pins 26..21 never drive, so a device holds them to keep reads defined
    logic [31:0] ext_val = 32'h0000_0000;
    logic [31:0] ext_en = 32'h07E0_0000;
    int          bad_count = 0;
    int          total_checks = 0;

    always #5 mclk_i = ~mclk_i;

    gpp_port uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
        .pulldown_en_o(pulldown_en_o), .pin_routing_o(pin_routing_o),
        .irq_n_o(irq_n_o));

    gpp_pin_model pins (.mclk_i(mclk_i), .pin_o_i(pin_o),
        .pin_oe_n_i(pin_oe_n_o), .pulldown_en_i(pulldown_en_o),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pin_i));

    task automatic give_verdict();
        $display("Checks made: %0d, mismatches: %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        chk({16'h0000, rdata_o}, {16'h0000, exp});
    endtask : rdchk

    // Lets a write reach the mirrored outputs before they are looked at
    task automatic settle();
        @(posedge mclk_i);
        #1;
    endtask : settle

    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge mclk_i);
        #1;
        chk(pin_oe_n_o, 32'hFFFF_FFFF);
        chk(pin_o, 32'h0000_0000);
        chk(pulldown_en_o, USABLE_PINS);
        chk({15'h0000, irq_n_o, pin_routing_o}, 32'h0001_0000);
        rst_n_i <= 1'b1;
        for (int a = 16'h1C06; a <= 16'h1C11; a++) begin
            rdchk(16'(a), 16'h0000);
        end
        rdchk(16'h1C01, 16'h0000);
        wr(16'h1C12, 16'hFFFF);
        rdchk(16'h1C12, 16'h0000);
        wr(16'h1C06, 16'hFFFF);
        wr(16'h1C07, 16'hFFFF);
        wr(16'h1C0A, 16'hA5C3);
        wr(16'h1C0B, 16'h5A3C);
        settle();
        chk(pin_oe_n_o, 32'h07E0_0000);
        chk(pin_o, 32'h5A3C_A5C3);
        rdchk(16'h1C07, 16'hF81F);
        rdchk(16'h1C08, 16'hA5C3);
        rdchk(16'h1C09, 16'h581C);
        ext_val <= 32'h0000_1234;
        ext_en  <= 32'hFFFF_FFFF;
        wr(16'h1C06, 16'h0000);
        wr(16'h1C07, 16'h0000);
        wr(16'h1C17, 16'hFFFF);
        settle();
        chk(pulldown_en_o, 32'hF81F_0000);
        rdchk(16'h1C08, 16'h1234);
        wr(16'h1C0C, 16'h0004);
        wr(16'h1C0E, 16'h0005);
        wr(16'h1C0F, 16'h8000);
        ext_val <= 32'h8000_123D;
        repeat (6) @(posedge mclk_i);
        #1;
        chk({31'h0, irq_n_o}, 32'h0000_0000);
        rdchk(16'h1C10, 16'h0001);
        rdchk(16'h1C11, 16'h8000);
        ext_val <= 32'h8000_1238;
        repeat (6) @(posedge mclk_i);
        rdchk(16'h1C10, 16'h0005);
        wr(16'h1C10, 16'h0001);
        rdchk(16'h1C10, 16'h0004);
        chk({31'h0, irq_n_o}, 32'h0000_0000);
        wr(16'h1C11, 16'hFFFF);
        wr(16'h1C10, 16'h0004);
        settle();
        chk({31'h0, irq_n_o}, 32'h0000_0001);
        wr(16'h1C0C, 16'h0002);
        wr(16'h1C0E, 16'h001A);
        ext_val <= 32'h8000_1222;
        repeat (6) @(posedge mclk_i);
        rdchk(16'h1C10, 16'h0000);
        ext_val <= 32'h8000_1238;
        repeat (6) @(posedge mclk_i);
        rdchk(16'h1C10, 16'h001A);
        wr(16'h1C10, 16'h0018);
        rdchk(16'h1C10, 16'h0002);
        wr(16'h1C10, 16'h0002);
        settle();
        chk({31'h0, irq_n_o}, 32'h0000_0001);
        // Peripheral clocks count as gated; routing is set once only
        wr(16'h1C00, 16'h0003);
        settle();
        chk({16'h0000, pin_routing_o}, 32'h0000_0003);
        rst_n_i <= 1'b0;
        settle();
        chk(pin_oe_n_o, 32'hFFFF_FFFF);
        chk({16'h0000, pin_routing_o}, 32'h0000_0000);
        rst_n_i <= 1'b1;
        rdchk(16'h1C0F, 16'h0000);
        give_verdict();
    end
endmodule : tb

`default_nettype wire
